// [ftfri_crc.sv]
// Running CRC register for the written address marks and fields.
// Assumes clr and en are never high together.
`timescale 1ns/1ns
module ftfri_crc (
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                clr,
	input  wire logic                en,
	input  wire logic [7:0]          din,
	output      logic [15:0]         crc_q
);
	import ftfri_pkg::*;

	typedef struct packed {
		logic [15:0] crc;
	} ftfri_crc_st_t;

	ftfri_crc_st_t s_q;
	ftfri_crc_st_t s_d;

	always_comb begin
		s_d = s_q;
		// [RULE20] preset then step
		if (clr) begin
			s_d.crc = CRC_PRESET;
		end else if (en) begin
			s_d.crc = crc_step(s_q.crc, din);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign crc_q = s_q.crc;

	// [RULE20] preset check
	a_crc_preset: assert property ( // [RULE20]
		@(posedge pclk) disable iff (!presetn)
		clr |=> crc_q == CRC_PRESET
	) else $error("CRC not preset after clear");
endmodule

// [ftfri_drv.sv]
// Drive-side model: index pulses, serialiser byte pacing, read stream.
// Assumes pclk domain; the testbench calls idx and send.
`timescale 1ns/1ns
module ftfri_drv (
	input  wire logic       pclk,
	output      logic       index_pulse_in,
	output      logic       byte_tick,
	output      logic       rd_valid,
	output      logic [7:0] rd_byte,
	output      logic       rd_mark
);
	logic [1:0] div_q = 2'h0;
	initial begin
		index_pulse_in = 1'b0;
		rd_valid = 1'b0;
		rd_byte = 8'h00;
		rd_mark = 1'b0;
	end
	// Serialiser wants a byte every fourth clock
	always @(posedge pclk) begin
		div_q <= div_q + 2'h1;
	end
	assign byte_tick = (div_q == 2'h3);
	task automatic idx();
		@(posedge pclk);
		index_pulse_in <= 1'b1;
		repeat (2) @(posedge pclk);
		index_pulse_in <= 1'b0;
	endtask
	// Stale byte inverted so nothing passes on a held value
	task automatic send(input logic [7:0] b, input logic m);
		@(posedge pclk);
		rd_valid <= 1'b1;
		rd_byte <= b;
		rd_mark <= m;
		@(posedge pclk);
		rd_valid <= 1'b0;
		rd_byte <= ~b;
		rd_mark <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask
endmodule

// [ftfri_idscan.sv]
// Read ID scanner: hunts the first ID field with a good CRC.
// Assumes the separator flags mark bytes (missing clock) on rd_mark.
`timescale 1ns/1ns
module ftfri_idscan (
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                start,
	input  wire logic                dd,
	input  wire logic                idx_rise,
	input  wire logic                rd_valid,
	input  wire logic [7:0]          rd_byte,
	input  wire logic                rd_mark,
	output      logic                done,
	output      logic                found,
	output      logic [31:0]         id
);
	import ftfri_pkg::*;

	typedef enum logic [1:0] {I_IDLE, I_HUNT, I_FLD} ftfri_scan_t;
	typedef struct packed {
		ftfri_scan_t st;
		logic [1:0]  nidx;
		logic [1:0]  pre;
		logic [2:0]  cnt;
		logic [15:0] crc;
		logic [31:0] id;
		logic        done;
		logic        found;
	} ftfri_scan_st_t;

	ftfri_scan_st_t q;
	ftfri_scan_st_t d;

	always_comb begin
		d = q;
		d.done = 1'b0;
		unique case (q.st)
			I_IDLE: begin
				if (start) begin
					d.st = I_HUNT;
					d.nidx = 2'h0;
					d.pre = 2'h0;
					d.found = 1'b0;
				end
			end
			I_HUNT: begin
				if (rd_valid) begin
					if (dd && rd_mark && rd_byte == MK_PRE) begin
						d.pre = (q.pre == PRE_N) ? q.pre : q.pre + 2'h1;
					end else if ((dd ? q.pre == PRE_N : rd_mark)
						&& rd_byte == MK_IDAM) begin
						d.st = I_FLD;
						d.cnt = 3'h0;
						d.crc = crc_step(dd ? CRC_PRE3 : CRC_PRESET, rd_byte);
					end else begin
						d.pre = 2'h0;
					end
				end
			end
			I_FLD: begin
				if (rd_valid) begin
					d.crc = crc_step(q.crc, rd_byte);
					d.cnt = q.cnt + 3'h1;
					if (q.cnt < ID_LEN) begin
						d.id = {q.id[23:0], rd_byte};
					end
					// [RULE15] first good field
					if (q.cnt == ID_LAST) begin
						d.pre = 2'h0;
						if (d.crc == 16'h0000) begin
							d.st = I_IDLE;
							d.done = 1'b1;
							d.found = 1'b1;
						end else begin
							d.st = I_HUNT;
						end
					end
				end
			end
			default: d.st = I_IDLE;
		endcase
		// [RULE16] second index gives up
		if (q.st != I_IDLE && idx_rise && !d.done) begin
			d.nidx = q.nidx + 2'h1;
			if (q.nidx == 2'h1) begin
				d.st = I_IDLE;
				d.done = 1'b1;
				d.found = 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign done = q.done;
	assign found = q.found;
	assign id = q.id;

	// [RULE16] fail on second index
	a_second_index: assert property ( // [RULE16]
		@(posedge pclk) disable iff (!presetn)
		(q.st == I_HUNT && q.nidx == 2'h1 && idx_rise)
		|=> (done && !found && q.st == I_IDLE)
	) else $error("Read ID did not stop at second index");
endmodule

// [ftfri_pkg.sv]
// Constants, types and the CRC step shared by the format and Read ID logic.
// Assumes one clock domain; byte pacing comes from the drive-side serialiser.
package ftfri_pkg;
	localparam int ADDR_W = 8;

	localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_FMT  = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_IDW  = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_STAT = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_RES  = 8'h10;

	localparam int CB_FMT   = 0;
	localparam int CB_RDID  = 1;
	localparam int CB_SENSE = 2;
	localparam int CB_DD    = 3;
	localparam int CB_DEL   = 4;

	localparam int FP_N    = 0;
	localparam int FP_SPT  = 8;
	localparam int FP_GPL  = 16;
	localparam int FP_FILL = 24;

	localparam int SB_BUSY = 0;
	localparam int SB_IRQ  = 1;
	localparam int SB_IDE  = 2;
	localparam int SB_ST0  = 8;
	localparam int SB_ST1  = 16;
	localparam int ST0_TC  = 6;
	localparam int ST0_SE  = 5;
	localparam int ST1_MA  = 0;
	localparam int ST1_UND = 4;

	localparam logic [1:0] TC_NORMAL = 2'h0;
	localparam logic [1:0] TC_ABN    = 2'h1;

	localparam logic [7:0] GAP_DD     = 8'h4E;
	localparam logic [7:0] GAP_SD     = 8'hFF;
	localparam logic [7:0] SYNC_BYTE  = 8'h00;
	localparam logic [7:0] MK_IDX_PRE = 8'hC2;
	localparam logic [7:0] MK_PRE     = 8'hA1;
	localparam logic [7:0] MK_IAM     = 8'hFC;
	localparam logic [7:0] MK_IDAM    = 8'hFE;
	localparam logic [7:0] MK_DAM     = 8'hFB;
	localparam logic [7:0] MK_DDAM    = 8'hF8;
	localparam logic [7:0] N_MAX      = 8'h05;

	localparam logic [12:0] L_G4A_DD   = 13'h0050;
	localparam logic [12:0] L_G4A_SD   = 13'h0028;
	localparam logic [12:0] L_G1_DD    = 13'h0032;
	localparam logic [12:0] L_G1_SD    = 13'h001A;
	localparam logic [12:0] L_G2_DD    = 13'h0016;
	localparam logic [12:0] L_G2_SD    = 13'h000B;
	localparam logic [12:0] L_SYNC_DD  = 13'h000C;
	localparam logic [12:0] L_SYNC_SD  = 13'h0006;
	localparam logic [12:0] L_MARK_DD  = 13'h0004;
	localparam logic [12:0] L_MARK_SD  = 13'h0001;
	localparam logic [12:0] L_IDF      = 13'h0004;
	localparam logic [12:0] L_CRC      = 13'h0002;
	localparam logic [12:0] L_SEC_BASE = 13'h0080;
	localparam logic [12:0] L_G4B      = 13'h1FFF;
	localparam logic [12:0] L_MIN      = 13'h0001;

	localparam logic [1:0]  PRE_N   = 2'h3;
	localparam logic [2:0]  ID_LEN  = 3'h4;
	localparam logic [2:0]  ID_LAST = 3'h5;
	localparam logic [15:0] CRC_PRESET = 16'hFFFF;
	localparam logic [15:0] CRC_POLY   = 16'h1021;

	typedef enum logic [3:0] {
		F_GAP4A, F_SYNCI, F_IAM, F_GAP1, F_SYNCA, F_IDAM, F_IDF, F_CRC1,
		F_GAP2, F_SYNCD, F_DAM, F_DATA, F_CRC2, F_GAP3, F_GAP4B
	} ftfri_fld_t;

	function automatic logic [15:0] crc_step(logic [15:0] c, logic [7:0] b);
		logic [15:0] r;
		r = c;
		for (int i = 7; i >= 0; i--) begin
			if (r[15] ^ b[i]) begin
				r = {r[14:0], 1'b0} ^ CRC_POLY;
			end else begin
				r = {r[14:0], 1'b0};
			end
		end
		return r;
	endfunction

	localparam logic [15:0] CRC_PRE3 =
		crc_step(crc_step(crc_step(CRC_PRESET, MK_PRE), MK_PRE), MK_PRE);
endpackage

// [ftfri_top.sv]
// Format A Track and Read ID execution engine with an APB register slave.
// Assumes byte_tick paces write bytes and inputs are synchronous to pclk.
// Operation
// [RULE1] Format waits for an index pulse before writing the track.
// [RULE2] Double density: gaps 80, 50, 22 of 4E; 12 sync zeros per mark.
// [RULE3] Double density marks: 3xC2+FC, 3xA1+FE, 3xA1+FB or F8.
// [RULE4] Single density: gaps 40, 26, 11 of FF; 6 sync zeros; 1-byte marks.
// [RULE5] Size, sector count, gap length and fill come from command setup.
// [RULE6] Every data field byte is the fill byte.
// [RULE7] Host gives cylinder, head, sector, size per sector; written as ID.
// [RULE8] Host supplies the next four ID bytes before they are needed.
// [RULE9] Only sector number changes; any order of numbers is accepted.
// [RULE10] Sectors repeat until the next index pulse ends the command.
// [RULE11] Size codes 0..5 give 128 to 4096 byte sectors.
// [RULE12] Host should use the suggested gap values.
// [RULE13] Control commands move no data between host and disk.
// [RULE14] Interrupt on completion only for Read ID among these commands; the code also interrupts when Format ends or aborts.
// [RULE15] Read ID keeps the first good ID field read.
// [RULE16] No ID mark by second index: code 01, missing mark flag, end.
// [RULE17] Interrupting control commands return no result bytes.
// [RULE18] Host should follow with Sense Interrupt Status.
// [RULE19] Sense clears the interrupt and shows code and seek end flag.
// [RULE20] CRC-16 preset to ones follows every ID and data field.
//
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
module ftfri_top (
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [ftfri_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]                 pwdata,
	output      logic [31:0]                 prdata,
	output      logic                        pready,
	output      logic                        pslverr,
	input  wire logic                        index_pulse_in,
	input  wire logic                        byte_tick,
	input  wire logic                        rd_valid,
	input  wire logic [7:0]                  rd_byte,
	input  wire logic                        rd_mark,
	output      logic                        wr_gate,
	output      logic [7:0]                  wr_byte,
	output      logic                        wr_mark,
	output      logic                        irq
);
	import ftfri_pkg::*;

	typedef enum logic [1:0] {S_IDLE, S_WIDX, S_FMT, S_RDID} ftfri_st_t;
	typedef struct packed {
		ftfri_st_t   st;
		ftfri_fld_t  fld;
		logic [12:0] cnt;
		logic [7:0]  secs;
		logic        dd;
		logic        del;
		logic [31:0] fmt;
		logic [31:0] idb;
		logic        id_full;
		logic [31:0] cur;
		logic        irq;
		logic [1:0]  tc;
		logic        mam;
		logic        und;
		logic [31:0] res;
		logic        idx_prev;
		logic        scan_go;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
		logic        wr_gate;
		logic        wr_mark;
		logic [7:0]  wr_byte;
	} ftfri_state_t;

	ftfri_state_t s_q;
	ftfri_state_t s_d;
	logic         idx_rise;
	logic         crc_clr;
	logic         crc_en;
	logic [7:0]   crc_din;
	logic [15:0]  crc_val;
	logic         scan_done;
	logic         scan_found;
	logic [31:0]  scan_id;

	function automatic logic [12:0] fld_len(ftfri_fld_t f, logic dd,
		logic [7:0] gap_length, logic [7:0] n);
		logic [2:0] sh;
		sh = (n > N_MAX) ? N_MAX[2:0] : n[2:0];
		unique case (f)
			F_GAP4A: fld_len = dd ? L_G4A_DD : L_G4A_SD;
			F_GAP1: fld_len = dd ? L_G1_DD : L_G1_SD;
			F_GAP2: fld_len = dd ? L_G2_DD : L_G2_SD;
			F_SYNCI, F_SYNCA, F_SYNCD: fld_len = dd ? L_SYNC_DD : L_SYNC_SD;
			F_IAM, F_IDAM, F_DAM: fld_len = dd ? L_MARK_DD : L_MARK_SD;
			F_IDF: fld_len = L_IDF;
			F_CRC1, F_CRC2: fld_len = L_CRC;
			// [RULE11] size code shift
			F_DATA: fld_len = L_SEC_BASE << sh;
			F_GAP3: fld_len = (gap_length == 8'h00) ? L_MIN : {5'h00, gap_length};
			F_GAP4B: fld_len = L_G4B;
			default: fld_len = L_MIN;
		endcase
	endfunction

	function automatic logic [8:0] fld_byte(ftfri_fld_t f, logic dd,
		logic del, logic pre, logic [7:0] idb, logic [7:0] fill,
		logic [15:0] crc, logic lo);
		logic mk;
		mk = ~dd | pre;
		unique case (f)
			F_GAP4A, F_GAP1, F_GAP2, F_GAP3, F_GAP4B:
				fld_byte = {1'b0, dd ? GAP_DD : GAP_SD};
			F_SYNCI, F_SYNCA, F_SYNCD: fld_byte = {1'b0, SYNC_BYTE};
			F_IAM: fld_byte = {mk, pre ? MK_IDX_PRE : MK_IAM};
			F_IDAM: fld_byte = {mk, pre ? MK_PRE : MK_IDAM};
			F_DAM: fld_byte = {mk, pre ? MK_PRE : (del ? MK_DDAM : MK_DAM)};
			F_IDF: fld_byte = {1'b0, idb};
			F_DATA: fld_byte = {1'b0, fill};
			F_CRC1, F_CRC2: fld_byte = {1'b0, lo ? crc[7:0] : crc[15:8]};
			default: fld_byte = {1'b0, SYNC_BYTE};
		endcase
	endfunction

	assign idx_rise = index_pulse_in & ~s_q.idx_prev;

	always_comb begin
		logic [8:0]  mb;
		logic [12:0] len;
		logic [31:0] rd;
		logic [7:0]  st0;
		logic [7:0]  st1;
		logic        hit;
		logic        take;
		logic        wr_hit;
		mb = 9'h000;
		len = fld_len(s_q.fld, s_q.dd, s_q.fmt[FP_GPL +: 8],
			s_q.fmt[FP_N +: 8]);
		rd = 32'h0000_0000;
		hit = 1'b1;
		take = 1'b0;
		s_d = s_q;
		s_d.scan_go = 1'b0;
		s_d.idx_prev = index_pulse_in;
		crc_clr = 1'b0;
		crc_en = 1'b0;
		crc_din = 8'h00;
		// One wait state: read data is registered on the edge that raises pready
		s_d.pready = psel & penable & ~s_q.pready;
		wr_hit = psel & penable & s_q.pready & pwrite;
		st0 = 8'h00;
		st0[ST0_TC +: 2] = s_q.tc;
		st0[ST0_SE] = 1'b0;
		st1 = 8'h00;
		st1[ST1_MA] = s_q.mam;
		st1[ST1_UND] = s_q.und;
		unique case (paddr)
			OFF_CTRL: begin
				rd[CB_DD] = s_q.dd;
				rd[CB_DEL] = s_q.del;
			end
			OFF_FMT: rd = s_q.fmt;
			OFF_IDW: rd = s_q.idb;
			// [RULE17] status instead of result bytes
			OFF_STAT: begin
				rd[SB_BUSY] = s_q.st != S_IDLE;
				rd[SB_IRQ] = s_q.irq;
				rd[SB_IDE] = ~s_q.id_full;
				rd[SB_ST0 +: 8] = st0;
				rd[SB_ST1 +: 8] = st1;
			end
			OFF_RES: rd = s_q.res;
			default: hit = 1'b0;
		endcase
		if (s_d.pready) begin
			s_d.prdata = rd;
			s_d.pslverr = ~hit;
		end
		if (wr_hit && paddr == OFF_CTRL && s_q.st == S_IDLE) begin
			s_d.dd = pwdata[CB_DD];
			s_d.del = pwdata[CB_DEL];
			if (pwdata[CB_FMT]) begin
				s_d.st = S_WIDX;
				s_d.fld = F_GAP4A;
				s_d.cnt = 13'h0000;
				s_d.secs = 8'h00;
				s_d.mam = 1'b0;
				s_d.und = 1'b0;
			end else if (pwdata[CB_RDID]) begin
				s_d.st = S_RDID;
				s_d.scan_go = 1'b1;
				s_d.mam = 1'b0;
				s_d.und = 1'b0;
			end
		end
		// [RULE19] sense clears interrupt
		if (wr_hit && paddr == OFF_CTRL && pwdata[CB_SENSE]) begin
			s_d.irq = 1'b0;
		end
		unique case (s_q.st)
			S_IDLE: s_d.st = s_d.st;
			// [RULE1] wait for index
			S_WIDX: begin
				if (idx_rise) begin
					s_d.st = S_FMT;
					s_d.wr_gate = 1'b1;
				end
			end
			S_FMT: begin
				if (byte_tick) begin
					// [RULE2] [RULE3] [RULE4] [RULE6] field bytes
					mb = fld_byte(s_q.fld, s_q.dd, s_q.del,
						s_q.dd && s_q.cnt < L_MARK_DD - L_MIN,
						s_q.cur[31:24], s_q.fmt[FP_FILL +: 8], crc_val,
						s_q.cnt[0]);
					s_d.wr_mark = mb[8];
					s_d.wr_byte = mb[7:0];
					// [RULE20] CRC over marks and fields
					crc_clr = s_q.fld inside {F_SYNCI, F_SYNCA, F_SYNCD};
					crc_en = s_q.fld inside {F_IAM, F_IDAM, F_DAM, F_IDF,
						F_DATA};
					crc_din = mb[7:0];
					// [RULE7] ID bytes in order
					if (s_q.fld == F_IDF) begin
						s_d.cur = {s_q.cur[23:0], 8'h00};
					end
					if (s_q.cnt == len - L_MIN) begin
						s_d.cnt = 13'h0000;
						if (s_q.fld == F_GAP3) begin
							// [RULE5] sector count from setup
							s_d.secs = s_q.secs + 8'h01;
							if (s_q.secs + 8'h01 == s_q.fmt[FP_SPT +: 8]) begin
								s_d.fld = F_GAP4B;
							end else begin
								s_d.fld = F_SYNCA;
								take = 1'b1;
							end
						end else if (s_q.fld != F_GAP4B) begin
							s_d.fld = ftfri_fld_t'(4'(s_q.fld + 4'h1));
							take = s_q.fld == F_GAP1;
						end
					end else begin
						s_d.cnt = s_q.cnt + L_MIN;
					end
					// [RULE8] missing ID bytes abort the track
					if (take && !s_q.id_full) begin
						s_d.st = S_IDLE;
						s_d.wr_gate = 1'b0;
						s_d.wr_mark = 1'b0;
						s_d.tc = TC_ABN;
						s_d.und = 1'b1;
						s_d.irq = 1'b1;
					end else if (take) begin
						s_d.cur = s_q.idb;
						s_d.id_full = 1'b0;
					end
				end
				// [RULE10] next index ends format
				if (idx_rise) begin
					s_d.st = S_IDLE;
					s_d.wr_gate = 1'b0;
					s_d.wr_mark = 1'b0;
					s_d.tc = TC_NORMAL;
					s_d.irq = 1'b1;
				end
			end
			S_RDID: begin
				// [RULE14] [RULE15] [RULE16] Read ID completion
				if (scan_done) begin
					s_d.st = S_IDLE;
					s_d.irq = 1'b1;
					s_d.tc = scan_found ? TC_NORMAL : TC_ABN;
					s_d.mam = ~scan_found;
					if (scan_found) begin
						s_d.res = scan_id;
					end
				end
			end
		endcase
		// [RULE5] parameters only while idle
		if (wr_hit && paddr == OFF_FMT && s_q.st == S_IDLE) begin
			s_d.fmt = pwdata;
		end
		// [RULE9] [RULE13] any ID accepted, none during Read ID
		if (wr_hit && paddr == OFF_IDW && s_q.st != S_RDID) begin
			s_d.idb = pwdata;
			s_d.id_full = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	ftfri_crc u_crc (
		.pclk    (pclk),
		.presetn (presetn),
		.clr     (crc_clr),
		.en      (crc_en),
		.din     (crc_din),
		.crc_q   (crc_val)
	);

	ftfri_idscan u_scan (
		.pclk     (pclk),
		.presetn  (presetn),
		.start    (s_q.scan_go),
		.dd       (s_q.dd),
		.idx_rise (idx_rise),
		.rd_valid (rd_valid),
		.rd_byte  (rd_byte),
		.rd_mark  (rd_mark),
		.done     (scan_done),
		.found    (scan_found),
		.id       (scan_id)
	);

	assign prdata = s_q.prdata;
	assign pready = s_q.pready;
	assign pslverr = s_q.pslverr;
	assign wr_gate = s_q.wr_gate;
	assign wr_byte = s_q.wr_byte;
	assign wr_mark = s_q.wr_mark;
	assign irq = s_q.irq;

	// [RULE1] gate opens on index
	a_gate_on_index: assert property ( // [RULE1]
		@(posedge pclk) disable iff (!presetn)
		$rose(wr_gate) |-> $past(idx_rise) && $past(s_q.st) == S_WIDX
	) else $error("Write gate opened without index");

	// [RULE2] double density gap
	a_dd_gap_byte: assert property ( // [RULE2]
		@(posedge pclk) disable iff (!presetn)
		(s_q.st == S_FMT && byte_tick && !idx_rise && s_q.dd
		 && s_q.fld == F_GAP1) |=> (wr_byte == GAP_DD && !wr_mark)
	) else $error("Double density gap byte wrong");

	// [RULE3] ID mark sequence
	a_dd_id_mark: assert property ( // [RULE3]
		@(posedge pclk) disable iff (!presetn)
		(s_q.st == S_FMT && byte_tick && !idx_rise && s_q.dd
		 && s_q.fld == F_IDAM) |=> (wr_byte == ($past(s_q.cnt) ==
		 L_MARK_DD - L_MIN ? MK_IDAM : MK_PRE))
	) else $error("Double density ID mark wrong");

	// [RULE4] single density mark
	a_sd_id_mark: assert property ( // [RULE4]
		@(posedge pclk) disable iff (!presetn)
		(s_q.st == S_FMT && byte_tick && !idx_rise && !s_q.dd
		 && s_q.fld == F_IDAM) |=> (wr_byte == MK_IDAM && wr_mark
		 && s_q.fld == F_IDF)
	) else $error("Single density ID mark wrong");

	// [RULE6] fill byte
	a_fill_byte: assert property ( // [RULE6]
		@(posedge pclk) disable iff (!presetn)
		(s_q.st == S_FMT && byte_tick && !idx_rise && s_q.fld == F_DATA)
		|=> wr_byte == s_q.fmt[FP_FILL +: 8]
	) else $error("Data field byte is not the fill byte");

	// [RULE10] index ends format
	a_index_ends: assert property ( // [RULE10]
		@(posedge pclk) disable iff (!presetn)
		(s_q.st == S_FMT && idx_rise)
		|=> (!wr_gate && irq && s_q.st == S_IDLE && s_q.tc == TC_NORMAL)
	) else $error("Format did not end on index");

	// [RULE13] no writing in Read ID
	a_rdid_quiet: assert property ( // [RULE13]
		@(posedge pclk) disable iff (!presetn)
		s_q.st == S_RDID |-> !wr_gate && !wr_mark ##1 $stable(s_q.idb)
	) else $error("Disk written during Read ID");

	// [RULE16] missing mark report
	a_rdid_missing: assert property ( // [RULE16]
		@(posedge pclk) disable iff (!presetn)
		(s_q.st == S_RDID && scan_done && !scan_found)
		|=> (s_q.tc == TC_ABN && s_q.mam && irq)
	) else $error("Missing mark not reported");

	// [RULE19] sense clears interrupt
	a_sense_clear: assert property ( // [RULE19]
		@(posedge pclk) disable iff (!presetn)
		(psel && penable && pready && pwrite && paddr == OFF_CTRL
		 && pwdata[CB_SENSE] && s_q.st == S_IDLE) |=> !irq
	) else $error("Sense did not clear interrupt");
endmodule

// [ftfri_top_tb.sv]
// Self-checking bench: APB master, format stream capture, Read ID.
// Assumes the drive model paces bytes and makes index pulses.
`timescale 1ns/1ns
module ftfri_top_tb;
	import ftfri_pkg::*;
	logic        pclk = 1'b0;
	logic        presetn, psel, penable, pwrite, e, tick_d, gate_d;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, r;
	logic        pready, pslverr, index_pulse_in, byte_tick;
	logic        rd_valid, rd_mark, wr_gate, wr_mark, irq;
	logic [7:0]  rd_byte, wr_byte;
	logic [8:0]  exp_q[$];
	logic [8:0]  got_q[$];
	logic [31:0] ids [2];
	logic [15:0] crc_v;
	int          bad_count = 0;
	int          n_tests = 0;
	always #20 pclk = ~pclk;
	ftfri_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .index_pulse_in(index_pulse_in),
		.byte_tick(byte_tick), .rd_valid(rd_valid), .rd_byte(rd_byte),
		.rd_mark(rd_mark), .wr_gate(wr_gate), .wr_byte(wr_byte),
		.wr_mark(wr_mark), .irq(irq));
	ftfri_drv drv (.pclk(pclk), .index_pulse_in(index_pulse_in),
		.byte_tick(byte_tick), .rd_valid(rd_valid), .rd_byte(rd_byte),
		.rd_mark(rd_mark));
	// Written byte shows the cycle after its tick
	// Gate taken at the tick edge: a tick as the gate opens loads nothing
	always @(posedge pclk) begin
		tick_d <= byte_tick;
		gate_d <= wr_gate;
		if (tick_d && gate_d) got_q.push_back({wr_mark, wr_byte});
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] want);
		n_tests++;
		if (got !== want) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
		end
	endtask
	task automatic test_done;
		$display("TB: tests %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the watchdog ends a wait for the slave
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wirq(input int lim);
		int n;
		n = 0;
		while (irq !== 1'b1 && n < lim) begin
			@(posedge pclk);
			n++;
		end
	endtask
	function automatic logic [15:0] crc8(logic [15:0] c, logic [7:0] b);
		for (int i = 7; i >= 0; i--)
			c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? 16'h1021 : 16'h0000);
		return c;
	endfunction
	task automatic put(input int n, input logic [7:0] b, input logic m);
		repeat (n) begin
			exp_q.push_back({m, b});
			crc_v = crc8(crc_v, b);
		end
	endtask
	task automatic put_crc();
		logic [15:0] c;
		c = crc_v;
		put(1, c[15:8], 1'b0);
		put(1, c[7:0], 1'b0);
	endtask
	task automatic build(input logic dd, input int spt, input int g3,
		input logic [7:0] fill, input logic del, input int n);
		logic [7:0] g;
		int sy;
		g = dd ? 8'h4E : 8'hFF;
		sy = dd ? 12 : 6;
		exp_q = {};
		put(dd ? 80 : 40, g, 1'b0);
		put(sy, 8'h00, 1'b0);
		put(dd ? 3 : 0, 8'hC2, 1'b1);
		put(1, 8'hFC, !dd);
		put(dd ? 50 : 26, g, 1'b0);
		for (int s = 0; s < spt; s++) begin
			put(sy, 8'h00, 1'b0);
			crc_v = 16'hFFFF;
			put(dd ? 3 : 0, 8'hA1, 1'b1);
			put(1, 8'hFE, !dd);
			for (int k = 3; k >= 0; k--) put(1, ids[s][8*k +: 8], 1'b0);
			put_crc();
			put(dd ? 22 : 11, g, 1'b0);
			put(sy, 8'h00, 1'b0);
			crc_v = 16'hFFFF;
			put(dd ? 3 : 0, 8'hA1, 1'b1);
			put(1, del ? 8'hF8 : 8'hFB, !dd);
			put(128 << n, fill, 1'b0);
			put_crc();
			put(g3, g, 1'b0);
		end
	endtask
	task automatic fmt(input logic dd, input int spt, input logic [7:0] g3,
		input logic [7:0] fill, input logic del, input int n);
		int w;
		build(dd, spt, g3, fill, del, n);
		got_q = {};
		apb(1'b1, OFF_FMT, {fill, g3, spt[7:0], n[7:0]});
		apb(1'b1, OFF_IDW, ids[0]);
		apb(1'b1, OFF_CTRL, {27'h0, del, dd, 3'h1});
		repeat (40) @(posedge pclk);
		chk(wr_gate, 1'b0);
		drv.idx();
		for (int s = 1; s < spt; s++) begin
			w = 0;
			do begin
				apb(1'b0, OFF_STAT, 32'h0000_0000);
				w++;
			end while (r[SB_IDE] !== 1'b1 && w < 500);
			apb(1'b1, OFF_IDW, ids[s]);
		end
		w = 0;
		while (got_q.size() < exp_q.size() + 4 && w < 9000) begin
			@(posedge pclk);
			w++;
		end
		chk(irq, 1'b0);
		drv.idx();
		wirq(20);
		chk(irq, 1'b1);
		for (int i = 0; i < exp_q.size(); i++)
			chk(got_q[i], exp_q[i]);
		apb(1'b0, OFF_STAT, 32'h0000_0000);
		chk({r[15:14], r[1:0]}, 4'h2);
	endtask
	task automatic sense();
		apb(1'b1, OFF_CTRL, 32'h0000_0004);
		@(posedge pclk);
		chk(irq, 1'b0);
		apb(1'b0, OFF_STAT, 32'h0000_0000);
		chk(r[13], 1'b0);
	endtask
	initial begin
		repeat (20000) @(posedge pclk);
		bad_count++;
		test_done;
	end
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk({irq, wr_gate}, 2'h0);
		apb(1'b0, 8'h14, 32'h0000_0000);
		chk(r, 32'h0000_0000);
		chk(e, 1'b1);
		// Out-of-order sector numbers, only R differs
		ids[0] = 32'h0301_0700;
		ids[1] = 32'h0301_0200;
		fmt(1'b0, 1, 8'h1B, 8'hA5, 1'b0, 0);
		sense();
		fmt(1'b1, 2, 8'h05, 8'h3C, 1'b1, 1);
		sense();
		// Bad field first; only the good one counts
		apb(1'b1, OFF_CTRL, 32'h0000_0002);
		drv.send(8'hFE, 1'b1);
		for (int k = 0; k < 6; k++) drv.send(8'h11 + k[7:0], 1'b0);
		crc_v = crc8(16'hFFFF, 8'hFE);
		drv.send(8'hFE, 1'b1);
		for (int k = 3; k >= 0; k--) begin
			drv.send(ids[1][8*k +: 8], 1'b0);
			crc_v = crc8(crc_v, ids[1][8*k +: 8]);
		end
		drv.send(crc_v[15:8], 1'b0);
		drv.send(crc_v[7:0], 1'b0);
		wirq(10);
		chk(irq, 1'b1);
		apb(1'b0, OFF_RES, 32'h0000_0000);
		chk(r, ids[1]);
		sense();
		apb(1'b1, OFF_CTRL, 32'h0000_000A);
		drv.idx();
		repeat (20) @(posedge pclk);
		chk(irq, 1'b0);
		drv.idx();
		wirq(10);
		apb(1'b0, OFF_STAT, 32'h0000_0000);
		chk({r[16], r[15:14], r[1]}, 4'hB);
		sense();
		// ID buffer already consumed: the first sector start must abort
		apb(1'b1, OFF_CTRL, 32'h0000_0001);
		drv.idx();
		wirq(600);
		apb(1'b0, OFF_STAT, 32'h0000_0000);
		chk({r[20], r[15:14], r[0]}, 4'hA);
		chk(wr_gate, 1'b0);
		sense();
		test_done;
	end
endmodule
